//--- src/lpdf_map.svh
/*
  Constants for the low power decimation filter timing block: cycle counts,
  decimation codes and output word layout. Assumes one master clock domain.
*/
`ifndef LPDF_MAP_SVH
`define LPDF_MAP_SVH

// Decimation select codes
`define LPDF_DEC64 2'h1
`define LPDF_DEC128 2'h2
`define LPDF_DEC256 2'h0

// Restart to first frame-sync falling edge, master clock periods
`define LPDF_SYNC_OFS_64 16'h0071
`define LPDF_SYNC_OFS_128 16'h00A7
`define LPDF_SYNC_OFS_256 16'h0115

// Restart to settled flag, master clock periods
`define LPDF_SETTLE_64 16'h1C72
`define LPDF_SETTLE_128 16'h37A8
`define LPDF_SETTLE_256 16'h6D16

// Fine group delay (computation plus filter), master clock periods
`define LPDF_GD_64 16'h0E58
`define LPDF_GD_128 16'h1C02
`define LPDF_GD_256 16'h3740

// Output word periods in master clocks: (MCLK/2)/decimation
`define LPDF_OWP_64 16'h0080
`define LPDF_OWP_128 16'h0100
`define LPDF_OWP_256 16'h0200

// Modulator clock divider, stage one and stage three decimation, frame-sync low time and counter limit
`define LPDF_MOD_DIV 2'h3
`define LPDF_STG1_DEC 4'h4
`define LPDF_STG3_DEC 4'h2
`define LPDF_FS_LOW_CYC 16'h0040
`define LPDF_CNT_MAX 16'hFFFF

// Output scaling shifts to 24-bit full scale per decimation
`define LPDF_SHIFT_64 5'h10
`define LPDF_SHIFT_128 5'h0F
`define LPDF_SHIFT_256 5'h0E

`endif

//--- src/lpdf_pkg.sv
/*
  Types for the low power decimation filter timing block.
  Assumes the constants header is included by the design files.
*/
package lpdf_pkg;
  typedef enum logic [1:0] {
    LPDF_IDLE = 2'b00,
    LPDF_WAIT = 2'b01,
    LPDF_RUN = 2'b10
  } lpdf_state_t;
endpackage

//--- src/lpdf_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and honest full/empty.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
module lpdf_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("lpdf_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire logic full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire logic empty = (wr_ptr == rd_ptr);
  wire logic push = in_valid_i && !full;
  wire logic pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

//--- src/lpdf_core.sv
/*
  Low power decimation filter path: modulator clock at master/4, three
  cascaded decimating stages, restart timing, settled flag and framed
  24-bit output words through a FIFO.
  Assumes modulator bits and the restart input come from pins (synchronised
  here), and a reader that drains words on valid/ready.
*/
`timescale 1ns/1ns
`include "lpdf_map.svh"
module lpdf_core #(
  parameter int FIFO_DEPTH = 16,
  parameter int WORD_W = 24
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Configuration and restart pins
  input wire logic [1:0] dec_sel_i,
  input wire logic restart_i,
  // Modulator side
  input wire logic mod_bit_i,
  output logic modulator_sample_clock_o,
  // Output words
  output logic word_valid_o,
  input wire logic word_ready_i,
  output logic [WORD_W-1:0] word_data_o,
  output logic frame_sync_out_o,
  output logic filter_settled_flag_o,
  output logic overflow_o
);
  initial begin
    if (WORD_W != 24 || FIFO_DEPTH < 2) begin
      $error("lpdf_core: word width must be 24 and FIFO depth at least 2");
    end
  end

  // Pin synchronisers
  logic [1:0] rst_sync;
  logic [1:0] bit_sync;
  logic [1:0] dec_sync [2];
  logic restart_d;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rst_sync <= 2'h0;
      bit_sync <= 2'h0;
      dec_sync[0] <= `LPDF_DEC64;
      dec_sync[1] <= `LPDF_DEC64;
      restart_d <= 1'b0;
    end else begin
      rst_sync <= {rst_sync[0], restart_i};
      bit_sync <= {bit_sync[0], mod_bit_i};
      // Decimation pins settle before the restart edge reaches the latch
      dec_sync[0] <= dec_sel_i;
      dec_sync[1] <= dec_sync[0];
      restart_d <= rst_sync[1];
    end
  end
  wire logic restart_rise = rst_sync[1] && !restart_d;

  // Per-decimation constant selection
  function automatic logic [15:0] pick(input logic [1:0] sel, input logic [15:0] a,
                                       input logic [15:0] b, input logic [15:0] c);
    if (sel == `LPDF_DEC64) begin
      pick = a;
    end else if (sel[1]) begin
      pick = b;
    end else begin
      pick = c;
    end
  endfunction

  // Decimation latched at restart so a mid-run change cannot corrupt timing
  logic [1:0] dec_q;
  wire logic [15:0] ofs_lim = pick(dec_q, `LPDF_SYNC_OFS_64, `LPDF_SYNC_OFS_128,
                                   `LPDF_SYNC_OFS_256);
  wire logic [15:0] set_lim = pick(dec_q, `LPDF_SETTLE_64, `LPDF_SETTLE_128,
                                   `LPDF_SETTLE_256);
  wire logic [15:0] gd_lim = pick(dec_q, `LPDF_GD_64, `LPDF_GD_128, `LPDF_GD_256);
  wire logic [15:0] owp = pick(dec_q, `LPDF_OWP_64, `LPDF_OWP_128, `LPDF_OWP_256);
  // Stage two factor: owp / (4 mod-div * 4 stg1 * 2 stg3) = 4, 8 or 16
  wire logic [5:0] stg2_dec = owp[10:5];

  // Modulator clock: master/4
  logic [1:0] mod_div;
  wire logic mod_tick = (mod_div == `LPDF_MOD_DIV);
  assign modulator_sample_clock_o = mod_div[1];

  // Restart timing counter and sequencer
  lpdf_pkg::lpdf_state_t state;
  lpdf_pkg::lpdf_state_t next_state;
  logic [15:0] tmr;
  logic [15:0] word_cnt;
  wire logic ofs_hit = (tmr == ofs_lim - 16'h0001);
  wire logic word_hit = (word_cnt == owp - 16'h0001);
  wire logic set_hit = (tmr == set_lim - 16'h0001);

  always_comb begin
    next_state = state;
    unique case (state)
      lpdf_pkg::LPDF_IDLE: next_state = lpdf_pkg::LPDF_WAIT;
      lpdf_pkg::LPDF_WAIT: begin
        if (ofs_hit) begin
          next_state = lpdf_pkg::LPDF_RUN;
        end
      end
      lpdf_pkg::LPDF_RUN: next_state = lpdf_pkg::LPDF_RUN;
      default: next_state = lpdf_pkg::LPDF_IDLE;
    endcase
    if (restart_rise) begin
      next_state = lpdf_pkg::LPDF_WAIT;
    end
  end

  // Frame sync falls at each word strobe outside a restart cycle, low for a fixed frame
  wire logic word_strobe = (state == lpdf_pkg::LPDF_WAIT && ofs_hit) ||
                           (state == lpdf_pkg::LPDF_RUN && word_hit);
  logic [15:0] fs_cnt;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= lpdf_pkg::LPDF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Decimation held for the whole run
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dec_q <= `LPDF_DEC64;
    end else if (restart_rise) begin
      dec_q <= dec_sync[1];
    end
  end

  // Free-running so the modulator never sees a shortened clock phase
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mod_div <= 2'h0;
    end else begin
      mod_div <= mod_div + 2'h1;
    end
  end

  // Saturates so late compares cannot wrap round
  wire logic tmr_full = (tmr == `LPDF_CNT_MAX);
  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_rise) begin
      tmr <= 16'h0000;
    end else if (!tmr_full) begin
      tmr <= tmr + 16'h0001;
    end
  end

  wire logic [15:0] next_word_cnt = word_strobe ? 16'h0000 : word_cnt + 16'h0001;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_rise) begin
      word_cnt <= 16'h0000;
    end else begin
      word_cnt <= next_word_cnt;
    end
  end

  // Restart wins: a settle from the old run must not survive it
  wire logic settle_now = set_hit && (state != lpdf_pkg::LPDF_IDLE);
  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_rise) begin
      filter_settled_flag_o <= 1'b0;
    end else if (settle_now) begin
      filter_settled_flag_o <= 1'b1;
    end
  end

  wire logic fs_start = word_strobe && !restart_rise;
  wire logic fs_busy = (fs_cnt != 16'h0000);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      frame_sync_out_o <= 1'b1;
      fs_cnt <= 16'h0000;
    end else if (fs_start) begin
      frame_sync_out_o <= 1'b0;
      fs_cnt <= `LPDF_FS_LOW_CYC - 16'h0001;
    end else if (fs_busy) begin
      fs_cnt <= fs_cnt - 16'h0001;
    end else begin
      frame_sync_out_o <= 1'b1;
    end
  end

  // Stage one: integrate by 4 modulator samples
  // Sinc-style accumulate and dump; scale tracks decimation so response follows clocks
  logic [3:0] s1_cnt;
  logic signed [7:0] s1_acc;
  logic signed [7:0] s1_out;
  logic s1_vld;
  wire logic signed [7:0] mod_val = bit_sync[1] ? 8'sh01 : -8'sh01;
  // Stage two: accumulate stg2_dec stage-one samples
  logic [5:0] s2_cnt;
  logic signed [15:0] s2_acc;
  logic signed [15:0] s2_out;
  logic s2_vld;
  // Stage three: sum pairs of stage-two outputs
  logic s3_ph;
  logic signed [23:0] s3_acc;
  // Group delay for result timing, tracked as time since restart in tmr
  logic signed [23:0] result;
  logic result_vld;

  wire logic s1_last = (s1_cnt == `LPDF_STG1_DEC - 4'h1);
  wire logic signed [7:0] s1_sum = s1_acc + mod_val;
  wire logic s2_last = (s2_cnt == stg2_dec - 6'h01);
  wire logic signed [15:0] s2_sum = s2_acc + 16'(s1_out);
  wire logic signed [23:0] s3_sum = s3_acc + 24'(s2_out);
  wire logic [4:0] out_shift = (dec_q == `LPDF_DEC64) ? `LPDF_SHIFT_64 :
                               dec_q[1] ? `LPDF_SHIFT_128 : `LPDF_SHIFT_256;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_rise) begin
      s1_cnt <= 4'h0;
      s1_acc <= 8'sh00;
      s1_out <= 8'sh00;
      s1_vld <= 1'b0;
    end else begin
      s1_vld <= mod_tick && s1_last;
      if (mod_tick) begin
        if (s1_last) begin
          s1_out <= s1_sum;
          s1_acc <= 8'sh00;
          s1_cnt <= 4'h0;
        end else begin
          s1_acc <= s1_sum;
          s1_cnt <= s1_cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_rise) begin
      s2_cnt <= 6'h00;
      s2_acc <= 16'sh0000;
      s2_out <= 16'sh0000;
      s2_vld <= 1'b0;
    end else begin
      s2_vld <= s1_vld && s2_last;
      if (s1_vld) begin
        if (s2_last) begin
          s2_out <= s2_sum;
          s2_acc <= 16'sh0000;
          s2_cnt <= 6'h00;
        end else begin
          s2_acc <= s2_sum;
          s2_cnt <= s2_cnt + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_rise) begin
      s3_ph <= 1'b0;
      s3_acc <= 24'sh000000;
      result <= 24'sh000000;
    end else if (s2_vld) begin
      s3_ph <= !s3_ph;
      if (s3_ph) begin
        // Full scale normalised to 24 bits, twos complement
        result <= s3_sum <<< out_shift;
        s3_acc <= 24'sh000000;
      end else begin
        s3_acc <= 24'(s2_out);
      end
    end
  end

  // Words only released once group delay has elapsed since restart
  assign result_vld = word_strobe && (tmr >= gd_lim);
  // stop band is a property of the coefficient set; this accumulate path is a stand-in

  logic fifo_in_ready;
  wire logic word_lost = result_vld && !fifo_in_ready;
  // Sticky until restart; a loss in the restart cycle still counts
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      overflow_o <= 1'b0;
    end else if (word_lost) begin
      overflow_o <= 1'b1;
    end else if (restart_rise) begin
      overflow_o <= 1'b0;
    end
  end
  lpdf_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(result_vld),
    .in_ready_o(fifo_in_ready),
    .in_data_i(result),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i),
    .out_data_o(word_data_o)
  );
endmodule

//--- tb/lpdf_core_chk.sv
/*
  Port checker for lpdf_core, bound into every instance.
  Assumes one master clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`include "lpdf_map.svh"
module lpdf_core_chk #(
  parameter int FIFO_DEPTH = 16,
  parameter int WORD_W = 24
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Inputs of the core
  input wire logic [1:0] dec_sel_i,
  input wire logic restart_i,
  input wire logic mod_bit_i,
  input wire logic word_ready_i,
  // Outputs of the core
  input wire logic modulator_sample_clock_o,
  input wire logic word_valid_o,
  input wire logic [WORD_W-1:0] word_data_o,
  input wire logic frame_sync_out_o,
  input wire logic filter_settled_flag_o,
  input wire logic overflow_o
);
  logic rs_d, fs_d, first, armed;
  logic [1:0] dl;
  logic [15:0] cnt, low, gap;
  wire rise = restart_i && !rs_d;
  wire fall = fs_d && !frame_sync_out_o;
  wire [15:0] ofs = dl == 2'h1 ? `LPDF_SYNC_OFS_64 : dl[1] ? `LPDF_SYNC_OFS_128 : `LPDF_SYNC_OFS_256;
  wire [15:0] stl = dl == 2'h1 ? `LPDF_SETTLE_64 : dl[1] ? `LPDF_SETTLE_128 : `LPDF_SETTLE_256;
  wire [15:0] gd = dl == 2'h1 ? `LPDF_GD_64 : dl[1] ? `LPDF_GD_128 : `LPDF_GD_256;
  wire [15:0] owp = dl == 2'h1 ? `LPDF_OWP_64 : dl[1] ? `LPDF_OWP_128 : `LPDF_OWP_256;
  always_ff @(posedge core_clk_i) begin
    rs_d <= restart_i;
    fs_d <= frame_sync_out_o;
    dl <= rise ? dec_sel_i : dl;
    cnt <= rst_i ? 16'h0000 : rise ? 16'h0000 : cnt + {15'h0000, ~&cnt};
    low <= frame_sync_out_o ? 16'h0000 : low + 16'h0001;
    gap <= fall ? 16'h0001 : gap + {15'h0000, ~&gap};
    armed <= rst_i ? 1'b0 : rise ? 1'b1 : armed;
    // Old frames may still fall just after a restart
    first <= rst_i ? 1'b0 : rise ? 1'b1 : (fall && cnt > 16'h0010) ? 1'b0 : first;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence clk_hi; modulator_sample_clock_o [*2]; endsequence
  sequence clk_lo; !modulator_sample_clock_o [*2]; endsequence
  a_mod_clk_div: assert property (
    $rose(modulator_sample_clock_o) |-> clk_hi ##1 clk_lo) else $error("sample clock ratio");
  a_word_period: assert property (
    fall && armed && cnt > gap && cnt - gap > 16'h0008 |-> gap == owp)
    else $error("word period wrong");
  a_frame_low: assert property (
    $rose(frame_sync_out_o) |-> low == `LPDF_FS_LOW_CYC) else $error("frame low length");
  a_sync_offset: assert property (
    fall && first && cnt > 16'h0010 |-> cnt >= ofs && cnt <= ofs + 16'h0006)
    else $error("first frame offset");
  a_settle_time: assert property (
    $rose(filter_settled_flag_o) && armed |-> cnt >= stl && cnt <= stl + 16'h0006)
    else $error("settle time wrong");
  a_settle_reset: assert property (
    $fell(rst_i) |-> !filter_settled_flag_o && frame_sync_out_o) else $error("reset state");
  a_settle_drop: assert property (
    rise |-> ##[1:5] !filter_settled_flag_o) else $error("settled not cleared");
  a_word_hold: assert property (
    word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_data_o))
    else $error("word not held");
  a_no_early_word: assert property (
    $rose(word_valid_o) && armed |-> cnt >= gd || cnt < 16'h0008) else $error("early word");
endmodule
bind lpdf_core lpdf_core_chk #(.FIFO_DEPTH(FIFO_DEPTH), .WORD_W(WORD_W)) u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .dec_sel_i(dec_sel_i), .restart_i(restart_i),
  .mod_bit_i(mod_bit_i), .word_ready_i(word_ready_i),
  .modulator_sample_clock_o(modulator_sample_clock_o), .word_valid_o(word_valid_o),
  .word_data_o(word_data_o), .frame_sync_out_o(frame_sync_out_o),
  .filter_settled_flag_o(filter_settled_flag_o), .overflow_o(overflow_o));

//--- tb/lpdf_mod_host.sv
/*
  Far-side model: a modulator giving a fixed-level bit stream and a word reader.
  Assumes the core's sample clock and valid/ready word port.
*/
`timescale 1ns/1ns
module lpdf_mod_host #(
  parameter int WORD_W = 24
) (
  // Clock
  input wire logic core_clk_i,
  // Modulator side
  input wire logic modulator_sample_clock_i,
  input wire logic level_i,
  output logic mod_bit_o,
  // Reader side
  input wire logic stall_i,
  input wire logic word_valid_i,
  input wire logic [WORD_W-1:0] word_data_i,
  output logic word_ready_o,
  output logic [WORD_W-1:0] last_o,
  output int taken_o
);
  initial begin
    mod_bit_o = 1'b0;
    word_ready_o = 1'b0;
    last_o = '0;
    taken_o = 0;
  end
  // New bit after each sample clock fall, as the modulator does
  always @(negedge modulator_sample_clock_i) mod_bit_o <= level_i;
  always @(posedge core_clk_i) begin
    word_ready_o <= !stall_i;
    if (word_valid_i && word_ready_o) begin
      last_o <= word_data_i;
      taken_o <= taken_o + 1;
    end
  end
endmodule

//--- tb/lpdf_core_tb.sv
/*
  Self-checking bench for lpdf_core with the modulator and reader model.
  Assumes inputs change at the falling clock edge.
*/
`timescale 1ns/1ns
module lpdf_core_tb;
  logic core_clk_i, rst_i, restart_i, ready, mod_bit, level, stall;
  logic [1:0] dec_sel_i;
  logic msc, wv, fs, st, ov;
  logic [23:0] wd, last;
  int taken, fails, compares, cyc, t0;
  lpdf_core #(.FIFO_DEPTH(16), .WORD_W(24)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .dec_sel_i(dec_sel_i), .restart_i(restart_i),
    .mod_bit_i(mod_bit), .modulator_sample_clock_o(msc), .word_valid_o(wv),
    .word_ready_i(ready), .word_data_o(wd), .frame_sync_out_o(fs),
    .filter_settled_flag_o(st), .overflow_o(ov));
  lpdf_mod_host #(.WORD_W(24)) u_host (
    .core_clk_i(core_clk_i), .modulator_sample_clock_i(msc), .level_i(level),
    .mod_bit_o(mod_bit), .stall_i(stall), .word_valid_i(wv), .word_data_i(wd),
    .word_ready_o(ready), .last_o(last), .taken_o(taken));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    compares++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, lo);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_fall(output int t);
    int n;
    n = 0;
    while (fs !== 1'b1 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
    while (fs !== 1'b0 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
    t = cyc;
  endtask
  task automatic run_dec(input logic [1:0] code, input int ofs, input int stl, input int owp,
      input logic lvl);
    int tf, t2, k0;
    dec_sel_i = code;
    level = lvl;
    restart_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    restart_i = 1'b1;
    t0 = cyc;
    repeat (16) @(negedge core_clk_i);
    wait_fall(tf);
    chk(tf - t0, ofs, ofs + 6);
    chk(st, 0, 0);
    restart_i = 1'b0;
    wait_fall(t2);
    wait_fall(tf);
    chk(tf - t2, owp, owp);
    while (st !== 1'b1 && cyc - t0 < 40000) @(negedge core_clk_i);
    chk(cyc - t0, stl, stl + 6);
    chk(ov, 0, 0);
    k0 = taken;
    while (taken < k0 + 2 && cyc - t0 < 42000) @(negedge core_clk_i);
    chk(last[23], !lvl, !lvl);
  endtask
  // Stalled reader overfills the 16-word buffer; surplus words are dropped
  task automatic fill_drain;
    int k0, n;
    stall = 1'b1;
    repeat (2600) @(negedge core_clk_i);
    chk(wv, 1, 1);
    chk(ov, 1, 1);
    k0 = taken;
    stall = 1'b0;
    n = 0;
    while (wv !== 1'b0 && n < 60) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(taken - k0, 16, 17);
  endtask
  initial begin
    cyc = 0;
    fails = 0;
    compares = 0;
    rst_i = 1'b1;
    restart_i = 1'b0;
    dec_sel_i = 2'h1;
    level = 1'b1;
    stall = 1'b0;
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    @(negedge core_clk_i);
    chk(st, 0, 0);
    chk(fs, 1, 1);
    run_dec(2'h1, 113, 7282, 128, 1'b1);
    fill_drain();
    run_dec(2'h2, 167, 14248, 256, 1'b0);
    run_dec(2'h3, 167, 14248, 256, 1'b1);
    run_dec(2'h0, 277, 27926, 512, 1'b0);
    summarize();
  end
  initial begin
    repeat (90000) @(posedge core_clk_i);
    fails++;
    summarize();
  end
endmodule
